// [verif/iwr_master.sv]
`timescale 1ns/100ps
// ----------------
// Bus master model
// ----------------
module iwr_master (
   input wire logic core_clk,
   input wire logic sda,
   output logic scl,
   output logic sda_rel
);
   initial begin
      scl = 1'b1;
      sda_rel = 1'b1;
   end
   // Quarter bit of 80 cycles, 390 kb/s
   task automatic qb;
      repeat (80) @(negedge core_clk);
   endtask
   task automatic start;
      sda_rel = 1'b1;
      scl = 1'b1;
      qb;
      sda_rel = 1'b0;
      qb;
      scl = 1'b0;
      qb;
   endtask
   task automatic stop;
      sda_rel = 1'b0;
      qb;
      scl = 1'b1;
      qb;
      sda_rel = 1'b1;
      qb;
   endtask
   // Every clock pulse except the one-cycle glitch spike comes from here
   task automatic bit_io(input logic b, output logic r);
      sda_rel = b;
      qb;
      scl = 1'b1;
      qb;
      r = sda;
      qb;
      scl = 1'b0;
      qb;
   endtask
   task automatic xfer(input logic [7:0] d, input logic ak,
      output logic [7:0] r, output logic a);
      for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
      bit_io(ak, a);
   endtask
   task automatic glitch;
      scl = 1'b1;
      @(negedge core_clk);
      scl = 1'b0;
   endtask
endmodule

// [verif/iwr_wiper_tb.sv]
`timescale 1ns/100ps
module iwr_wiper_tb;
   import iwr_pkg::*;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic brown_out = 1'b0;
   logic sda_o, sda_oe, scl_o, scl_oe, bus_active, m_scl, m_rel;
   logic [WIPER_W-1:0] tap_sel;
   logic [7:0] r;
   logic [1:0] k;
   logic a;
   int errors = 0;
   int num_checks = 0;
   int cyc = 0;
   // Open-drain wires with pull-up
   wire logic scl_w = m_scl & ~scl_oe;
   wire logic sda_w = m_rel & ~sda_oe;
   iwr_wiper #(.FILT_CYC(2)) dut_u (.core_clk(core_clk),
      .rst_b(rst_b), .brown_out(brown_out), .scl_i(scl_w),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .scl_o(scl_o),
      .scl_oe(scl_oe), .tap_sel(tap_sel), .bus_active(bus_active));
   iwr_master master_u (.core_clk(core_clk), .sda(sda_w),
      .scl(m_scl), .sda_rel(m_rel));
   initial begin
      forever #4 core_clk = ~core_clk;
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 90000) begin
         errors++;
         tally_and_finish;
      end
   end
   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      master_u.start;
      master_u.xfer(ad, 1'b1, r, k[1]);
      master_u.xfer(d, 1'b1, r, k[0]);
      master_u.stop;
   endtask
   task automatic t_reset;
      chk({1'b0, tap_sel}, 8'h3F);
      chk({4'h0, bus_active, sda_oe, scl_oe, sda_o}, 8'h00);
      $display("test reset done");
   endtask
   task automatic t_write;
      logic [7:0] v [3] = '{8'h00, 8'hFF, 8'h2A};
      foreach (v[i]) begin
         wr(8'h5E, v[i]);
         chk({6'h00, k}, 8'h00);
         chk({1'b0, tap_sel}, v[i] & 8'h7F);
         chk({7'h00, bus_active}, 8'h00);
      end
      $display("test write done");
   endtask
   task automatic t_read;
      master_u.start;
      master_u.xfer(8'h5F, 1'b1, r, a);
      chk({7'h00, a}, 8'h00);
      chk({7'h00, bus_active}, 8'h01);
      master_u.xfer(8'hFF, 1'b0, r, a);
      chk(r, 8'h2A);
      master_u.xfer(8'hFF, 1'b1, r, a);
      chk(r, 8'h2A);
      master_u.stop;
      chk({7'h00, bus_active}, 8'h00);
      $display("test read done");
   endtask
   task automatic t_refuse;
      wr(8'h5C, 8'h11);
      chk({6'h00, k}, 8'h03);
      wr(8'h00, 8'h11);
      chk({6'h00, k}, 8'h03);
      chk({1'b0, tap_sel}, 8'h2A);
      $display("test refuse done");
   endtask
   task automatic t_brown;
      brown_out = 1'b1;
      wr(8'h5E, 8'h55);
      chk({6'h00, k}, 8'h03);
      chk({1'b0, tap_sel}, 8'h2A);
      brown_out = 1'b0;
      repeat (20) @(negedge core_clk);
      wr(8'h5E, 8'h55);
      chk({1'b0, tap_sel}, 8'h55);
      $display("test brown done");
   endtask
   task automatic t_glitch;
      master_u.start;
      master_u.xfer(8'h5E, 1'b1, r, a);
      master_u.glitch;
      master_u.xfer(8'h33, 1'b1, r, a);
      master_u.stop;
      chk({1'b0, tap_sel}, 8'h33);
      $display("test glitch done");
   endtask
   task automatic t_por;
      rst_b = 1'b0;
      repeat (10) @(negedge core_clk);
      chk({1'b0, tap_sel}, 8'h3F);
      rst_b = 1'b1;
      repeat (20) @(negedge core_clk);
      chk({1'b0, tap_sel}, 8'h3F);
      wr(8'h5E, 8'h01);
      chk({6'h00, k}, 8'h00);
      chk({1'b0, tap_sel}, 8'h01);
      $display("test por done");
   endtask
   initial begin
      repeat (10) @(negedge core_clk);
      rst_b = 1'b1;
      repeat (20) @(negedge core_clk);
      t_reset;
      t_write;
      t_read;
      t_refuse;
      t_brown;
      t_glitch;
      t_por;
      tally_and_finish;
   end
endmodule

// [verilog/iwr_pkg.sv]
// Behaviour
// - Reset loads the wiper register with 3Fh, then digital operation begins.
// - During brown-out the serial interface stays disabled and ignores the bus.
// - Stop puts the interface idle; Start wakes it.
// - Wiper is written and read only over two-wire clock and data transfers.
// - Device is slave only and never drives the clock line.
// - Works at 100 kb/s and 400 kb/s; master stays at or below 400 kb/s.
// - Above reset trip the serial read and write commands still execute.
// - Code 00h selects the zero-scale tap.
// - Code 7Fh selects the full-scale tap; code is seven bits.
// - Data line is only pulled low or released, sampled through hysteresis.
// - Clock and data inputs are glitch filtered before use.
// - Only fixed address 0101111 after Start is answered.
// - General call is not acknowledged; data line stays released.
// - Clock is never held low to stretch a transfer.
// - Malformed commands release data and are ignored until next Start.
package iwr_pkg;
   localparam int CLK_HZ = 125000000;
   localparam int MAX_BIT_RATE_BPS = 400000;
   localparam int SPIKE_NS = 50;
   localparam int SPIKE_CYC = (SPIKE_NS * (CLK_HZ / 1000000) + 999) / 1000;
   localparam int WIPER_W = 7;
   localparam logic [6:0] WIPER_DEFAULT = 7'h3F;
   localparam logic [6:0] WIPER_ZERO = 7'h00;
   localparam logic [6:0] WIPER_FULL = 7'h7F;
   localparam logic [6:0] SLAVE_ADDR = 7'h2F;
   localparam logic [6:0] GEN_CALL = 7'h00;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ZERO = 4'h0;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_AACK = 3'b010,
      ST_WDATA = 3'b011,
      ST_WACK = 3'b100,
      ST_RDATA = 3'b101,
      ST_RACK = 3'b110,
      ST_IGNORE = 3'b111
   } iwr_state_t;
endpackage

// [verilog/iwr_wiper.sv]
`timescale 1ns/100ps
module iwr_wiper #(
   parameter int FILT_CYC = iwr_pkg::SPIKE_CYC
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic brown_out,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   output logic scl_o,
   output logic scl_oe,
   output logic [iwr_pkg::WIPER_W-1:0] tap_sel,
   output logic bus_active
);
   import iwr_pkg::*;

   // ------------------------------------------------------------
   // Synchronisers and glitch filters
   // ------------------------------------------------------------
   logic [1:0] scl_s_q, sda_s_q, scl_s_d, sda_s_d;
   logic [7:0] scl_cnt_q, sda_cnt_q, scl_cnt_d, sda_cnt_d;
   logic scl_f_q, sda_f_q, scl_f_d, sda_f_d;
   logic scl_p_q, sda_p_q;
   logic bo_s1_q, bo_s2_q;

   always_comb begin
      scl_s_d = {scl_s_q[0], scl_i};
      sda_s_d = {sda_s_q[0], sda_i};
      scl_cnt_d = 8'h00;
      sda_cnt_d = 8'h00;
      scl_f_d = scl_f_q;
      sda_f_d = sda_f_q;
      // Level must hold FILT_CYC cycles before it is taken
      if (scl_s_q[1] != scl_f_q) begin
         scl_cnt_d = scl_cnt_q + 8'h01;
         if (scl_cnt_q >= 8'(FILT_CYC - 1)) begin
            scl_f_d = scl_s_q[1];
            scl_cnt_d = 8'h00;
         end
      end
      if (sda_s_q[1] != sda_f_q) begin
         sda_cnt_d = sda_cnt_q + 8'h01;
         if (sda_cnt_q >= 8'(FILT_CYC - 1)) begin
            sda_f_d = sda_s_q[1];
            sda_cnt_d = 8'h00;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         scl_s_q <= 2'h3;
         sda_s_q <= 2'h3;
         scl_cnt_q <= 8'h00;
         sda_cnt_q <= 8'h00;
         scl_f_q <= 1'b1;
         sda_f_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
         bo_s1_q <= 1'b1;
         bo_s2_q <= 1'b1;
      end else begin
         scl_s_q <= scl_s_d;
         sda_s_q <= sda_s_d;
         scl_cnt_q <= scl_cnt_d;
         sda_cnt_q <= sda_cnt_d;
         scl_f_q <= scl_f_d;
         sda_f_q <= sda_f_d;
         scl_p_q <= scl_f_q;
         sda_p_q <= sda_f_q;
         bo_s1_q <= brown_out;
         bo_s2_q <= bo_s1_q;
      end
   end

   logic scl_rise, scl_fall, start_det, stop_det;
   assign scl_rise = scl_f_q && !scl_p_q;
   assign scl_fall = !scl_f_q && scl_p_q;
   assign start_det = scl_f_q && scl_p_q && sda_p_q && !sda_f_q;
   assign stop_det = scl_f_q && scl_p_q && !sda_p_q && sda_f_q;

   // ------------------------------------------------------------
   // Protocol engine
   // ------------------------------------------------------------
   iwr_state_t st_q, st_d;
   logic [3:0] bit_q, bit_d;
   logic [7:0] sh_q, sh_d;
   logic [6:0] wiper_q, wiper_d;
   logic drv_q, drv_d;

   always_comb begin
      st_d = st_q;
      bit_d = bit_q;
      sh_d = sh_q;
      wiper_d = wiper_q;
      drv_d = drv_q;
      if (bo_s2_q) begin
         // Interface held off during brown-out
         st_d = ST_IDLE;
         drv_d = 1'b0;
         bit_d = BIT_ZERO;
      end else if (stop_det) begin
         st_d = ST_IDLE;
         drv_d = 1'b0;
      end else if (start_det) begin
         st_d = ST_ADDR;
         bit_d = BIT_ZERO;
         drv_d = 1'b0;
      end else begin
         unique case (st_q)
            ST_IDLE, ST_IGNORE: begin
               drv_d = 1'b0;
            end
            ST_ADDR, ST_WDATA: begin
               if (scl_rise) begin
                  sh_d = {sh_q[6:0], sda_f_q};
                  bit_d = bit_q + 4'h1;
               end
               if (scl_fall && bit_q == BIT_LAST + 4'h1) begin
                  bit_d = BIT_ZERO;
                  if (st_q == ST_WDATA) begin
                     // Seven-bit code, 00h zero scale to 7Fh full
                     wiper_d = sh_q[6:0];
                     drv_d = 1'b1;
                     st_d = ST_WACK;
                  end else if (sh_q[7:1] == SLAVE_ADDR) begin
                     drv_d = 1'b1;
                     st_d = ST_AACK;
                  end else begin
                     // Other addresses and general call left unanswered
                     st_d = ST_IGNORE;
                  end
               end
            end
            ST_AACK, ST_WACK: begin
               if (scl_fall) begin
                  drv_d = 1'b0;
                  if (sh_q[0] && st_q == ST_AACK) begin
                     st_d = ST_RDATA;
                     sh_d = {1'b0, wiper_q};
                     // Bit 7 reads as zero, so pull low
                     drv_d = 1'b1;
                  end else begin
                     st_d = ST_WDATA;
                  end
               end
            end
            ST_RDATA: begin
               if (scl_fall) begin
                  bit_d = bit_q + 4'h1;
                  sh_d = {sh_q[6:0], 1'b0};
                  drv_d = !sh_q[6];
                  if (bit_q == BIT_LAST) begin
                     drv_d = 1'b0;
                     bit_d = BIT_ZERO;
                     st_d = ST_RACK;
                  end
               end
            end
            ST_RACK: begin
               // Master NACK ends the read; ACK reloads the next byte
               if (scl_rise && sda_f_q) begin
                  st_d = ST_IGNORE;
               end else if (scl_fall) begin
                  st_d = ST_RDATA;
                  sh_d = {1'b0, wiper_q};
                  bit_d = BIT_ZERO;
                  drv_d = 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= ST_IDLE;
         bit_q <= BIT_ZERO;
         sh_q <= 8'h00;
         wiper_q <= WIPER_DEFAULT;
         drv_q <= 1'b0;
      end else begin
         st_q <= st_d;
         bit_q <= bit_d;
         sh_q <= sh_d;
         wiper_q <= wiper_d;
         drv_q <= drv_d;
      end
   end

   // Open drain only: low or released
   assign sda_o = 1'b0;
   assign sda_oe = drv_q;
   // Clock never driven, never stretched
   assign scl_o = 1'b0;
   assign scl_oe = 1'b0;
   assign tap_sel = wiper_q;
   assign bus_active = (st_q != ST_IDLE);

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_clock_never_driven: assert property (@(posedge core_clk)
      disable iff (!rst_b) !scl_oe) else $error("scl driven");
   a_brownout_releases: assert property (@(posedge core_clk)
      disable iff (!rst_b) bo_s2_q |=> !sda_oe && st_q == ST_IDLE)
      else $error("bus active in brown-out");
   a_stop_to_idle: assert property (@(posedge core_clk)
      disable iff (!rst_b) stop_det && !bo_s2_q |=> st_q == ST_IDLE)
      else $error("stop did not idle");
   a_start_to_addr: assert property (@(posedge core_clk)
      disable iff (!rst_b) start_det && !bo_s2_q |=> st_q == ST_ADDR)
      else $error("start not taken");
   a_tap_stable: assert property (@(posedge core_clk)
      disable iff (!rst_b) !$stable(tap_sel) |-> $past(st_q) == ST_WDATA)
      else $error("tap changed without write");
   a_ignore_silent: assert property (@(posedge core_clk)
      disable iff (!rst_b) st_q == ST_IGNORE |-> !sda_oe)
      else $error("sda driven while ignoring");
   a_addr_ack_match: assert property (@(posedge core_clk)
      disable iff (!rst_b) $rose(st_q == ST_AACK) |->
      $past(sh_q[7:1]) == SLAVE_ADDR && sda_oe)
      else $error("ack without address match");
   a_no_gencall_ack: assert property (@(posedge core_clk)
      disable iff (!rst_b) st_q == ST_ADDR && scl_fall && !bo_s2_q &&
      bit_q == BIT_LAST + 4'h1 && sh_q[7:1] == GEN_CALL |=>
      st_q == ST_IGNORE && !sda_oe)
      else $error("general call answered");
   sequence s_byte_done;
      st_q == ST_WDATA && scl_fall && !bo_s2_q &&
      bit_q == BIT_LAST + 4'h1;
   endsequence
   sequence s_ack_held;
      st_q == ST_WACK && sda_oe && tap_sel == $past(sh_q[6:0]);
   endsequence
   a_write_lands: assert property (@(posedge core_clk)
      disable iff (!rst_b) s_byte_done |=> s_ack_held)
      else $error("write byte not loaded");
   a_sda_open_drain: assert property (@(posedge core_clk)
      disable iff (!rst_b) !sda_o) else $error("sda driven high");
endmodule
